// file: src/tsr_regbank.sv
// Top of the sensor register bank: feature report and sensor control words.
`timescale 1ns/1ps
`default_nettype none

module tsr_regbank (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic ptr_load_i,
    input wire logic [7:0] ptr_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic event_active_i,
    output logic [15:0] rd_data_o,
    output logic rd_hit_o,
    output logic [7:0] ptr_o,
    output tsr_pkg::tsr_control_t ctl_o,
    output logic [5:0] hyst_margin_o,
    output logic sensor_enable_o,
    output logic event_allowed_o,
    output logic event_clear_o,
    output logic crit_limit_locked_o,
    output logic win_limits_locked_o
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ptr_cur;
    logic feature_sel;
    logic control_sel;
    tsr_pkg::tsr_control_t ctl_cur;
    tsr_pkg::tsr_control_t ctl_view;
    logic ctl_wr;
    logic clear_pulse;
    logic [15:0] rd_mux;
    logic rd_hit_d;

    logic [15:0] rd_data_q;
    logic rd_hit_q;
    tsr_pkg::tsr_control_t ctl_out_q;
    logic [5:0] hyst_margin_q;
    logic sensor_enable_q;
    logic event_allowed_q;
    logic event_clear_q;
    logic crit_lock_q;
    logic win_lock_q;

    ////////////////////////////////////////////////////////////////////////////
    tsr_pointer u_pointer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .ptr_load_i(ptr_load_i),
        .ptr_i(ptr_i),
        .ptr_o(ptr_cur),
        .feature_sel_o(feature_sel),
        .control_sel_o(control_sel)
    );

    // A write to the feature location is accepted upstream but changes nothing.
    assign ctl_wr = wr_en_i & control_sel;

    tsr_control u_control (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .wr_i(ctl_wr),
        .wr_data_i(wr_data_i),
        .ctl_o(ctl_cur),
        .event_clear_o(clear_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status bit mirrors the live event state and reads 0 in shutdown, so it is never stale after a clear.
    always_comb begin
        ctl_view = ctl_cur;
        ctl_view.reserved_bits = '0;
        ctl_view.event_status = event_active_i & ~ctl_cur.sensor_shutdown;
    end

    assign rd_mux = feature_sel ? 16'(tsr_pkg::FEATURE_WORD) :
                    control_sel ? 16'(ctl_view) :
                    16'h0000;
    assign rd_hit_d = feature_sel | control_sel;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rd_data_q <= 16'h0000;
            rd_hit_q <= 1'b0;
        end else if (ce_i && rd_en_i) begin
            rd_data_q <= rd_mux;
            rd_hit_q <= rd_hit_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctl_out_q <= tsr_pkg::tsr_control_t'(tsr_pkg::CTL_RESET);
            hyst_margin_q <= tsr_pkg::MARGIN_OFF;
            sensor_enable_q <= 1'b0;
            event_allowed_q <= 1'b0;
            event_clear_q <= 1'b0;
            crit_lock_q <= 1'b0;
            win_lock_q <= 1'b0;
        end else if (ce_i) begin
            ctl_out_q <= ctl_view;
            hyst_margin_q <= tsr_pkg::hyst_margin(ctl_cur.hysteresis_select);
            sensor_enable_q <= ~ctl_cur.sensor_shutdown;
            event_allowed_q <= ctl_cur.event_output_enable & ~ctl_cur.sensor_shutdown;
            event_clear_q <= clear_pulse;
            crit_lock_q <= ctl_cur.critical_limit_lock;
            win_lock_q <= ctl_cur.window_limit_lock;
        end
    end

    assign rd_data_o = rd_data_q;
    assign rd_hit_o = rd_hit_q;
    assign ptr_o = ptr_cur;
    assign ctl_o = ctl_out_q;
    assign hyst_margin_o = hyst_margin_q;
    assign sensor_enable_o = sensor_enable_q;
    assign event_allowed_o = event_allowed_q;
    assign event_clear_o = event_clear_q;
    assign crit_limit_locked_o = crit_lock_q;
    assign win_limits_locked_o = win_lock_q;

endmodule

`default_nettype wire

// file: src/tsr_pkg.sv
// Constants, field layouts and carrier types for the sensor register bank.
`default_nettype none
package tsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] PTR_FEATURE_REPORT = 8'h00;
    localparam logic [7:0] PTR_SENSOR_CONTROL = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Fixed capability fields.
    localparam logic [9:0] CAP_RESERVED_BITS = 10'h000;
    localparam logic CAP_ADDRESS_PIN_VOLTAGE_STANDOFF = 1'b1;
    localparam logic [1:0] CAP_RESOLUTION_FIELD = 2'h2;
    localparam logic CAP_NEGATIVE_RANGE_SUPPORT = 1'b1;
    localparam logic CAP_ACCURACY_GRADE = 1'b1;
    localparam logic CAP_ALARM_CAPABILITY = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Control field positions and reset value.
    localparam int CTL_HYST_LSB = 9;
    localparam int CTL_SHUTDOWN_BIT = 8;
    localparam int CTL_CRIT_LOCK_BIT = 7;
    localparam int CTL_WIN_LOCK_BIT = 6;
    localparam int CTL_EVENT_STATUS_BIT = 4;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Hysteresis codes and margins in units of one result LSB (0.125 degC).
    localparam logic [1:0] HYST_OFF = 2'h0;
    localparam logic [1:0] HYST_1P5 = 2'h1;
    localparam logic [1:0] HYST_3P0 = 2'h2;
    localparam logic [1:0] HYST_6P0 = 2'h3;
    localparam logic [5:0] MARGIN_OFF = 6'h00;
    localparam logic [5:0] MARGIN_1P5 = 6'h0C;
    localparam logic [5:0] MARGIN_3P0 = 6'h18;
    localparam logic [5:0] MARGIN_6P0 = 6'h30;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [9:0] reserved_bits;
        logic address_pin_voltage_standoff;
        logic [1:0] resolution_field;
        logic negative_range_support;
        logic accuracy_grade;
        logic alarm_capability;
    } tsr_feature_t;

    typedef struct packed {
        logic [4:0] reserved_bits;
        logic [1:0] hysteresis_select;
        logic sensor_shutdown;
        logic critical_limit_lock;
        logic window_limit_lock;
        logic critical_only_event;
        logic event_status;
        logic event_output_enable;
        logic event_freeze;
        logic event_polarity;
        logic event_mode;
    } tsr_control_t;

    localparam tsr_feature_t FEATURE_WORD = '{
        reserved_bits: CAP_RESERVED_BITS,
        address_pin_voltage_standoff: CAP_ADDRESS_PIN_VOLTAGE_STANDOFF,
        resolution_field: CAP_RESOLUTION_FIELD,
        negative_range_support: CAP_NEGATIVE_RANGE_SUPPORT,
        accuracy_grade: CAP_ACCURACY_GRADE,
        alarm_capability: CAP_ALARM_CAPABILITY
    };

    ////////////////////////////////////////////////////////////////////////////
    // Maps a hysteresis select code to its margin.
    function automatic logic [5:0] hyst_margin(input logic [1:0] sel);
        logic [5:0] m;
        m = MARGIN_OFF;
        case (sel)
            HYST_1P5: m = MARGIN_1P5;
            HYST_3P0: m = MARGIN_3P0;
            HYST_6P0: m = MARGIN_6P0;
            default: m = MARGIN_OFF;
        endcase
        return m;
    endfunction

    // True when a pointer selects a location of this bank.
    function automatic logic ptr_is(input logic [7:0] ptr, input logic [7:0] loc);
        return ptr == loc;
    endfunction

endpackage
`default_nettype wire

// file: src/tsr_pointer.sv
// Pointer register and location decode for the sensor register bank.
`timescale 1ns/1ps
`default_nettype none

module tsr_pointer (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic ptr_load_i,
    input wire logic [7:0] ptr_i,
    output logic [7:0] ptr_o,
    output logic feature_sel_o,
    output logic control_sel_o
);

    logic [7:0] ptr_q;
    logic [7:0] ptr_d;

    ////////////////////////////////////////////////////////////////////////////
    assign ptr_d = ptr_load_i ? ptr_i : ptr_q;
    assign ptr_o = ptr_q;
    assign feature_sel_o = tsr_pkg::ptr_is(ptr_q, tsr_pkg::PTR_FEATURE_REPORT);
    assign control_sel_o = tsr_pkg::ptr_is(ptr_q, tsr_pkg::PTR_SENSOR_CONTROL);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ptr_q <= tsr_pkg::PTR_RESET;
        end else if (ce_i) begin
            ptr_q <= ptr_d;
        end
    end

endmodule

`default_nettype wire

// file: src/tsr_control.sv
// Storage of the control word with its lock and write-effect behaviour.
`timescale 1ns/1ps
`default_nettype none

module tsr_control (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [15:0] wr_data_i,
    output tsr_pkg::tsr_control_t ctl_o,
    output logic event_clear_o
);

    tsr_pkg::tsr_control_t ctl_q;
    tsr_pkg::tsr_control_t ctl_d;
    tsr_pkg::tsr_control_t wr_word;
    logic locked;
    logic event_clear_q;
    logic event_clear_d;
    logic shutdown_may_set;
    logic crit_lock_next;

    ////////////////////////////////////////////////////////////////////////////
    assign wr_word = tsr_pkg::tsr_control_t'(wr_data_i);
    assign locked = ctl_q.critical_limit_lock | ctl_q.window_limit_lock;
    assign event_clear_d = wr_i & wr_word.event_status;
    // Shutdown may always be cleared, but set only while unlocked.
    assign shutdown_may_set = !locked | ctl_q.sensor_shutdown;
    assign crit_lock_next = ctl_q.critical_limit_lock | wr_word.critical_limit_lock;

    always_comb begin
        ctl_d = ctl_q;
        if (wr_i) begin
            ctl_d.reserved_bits = '0;
            // Margin only changes while neither lock holds.
            if (!locked) begin
                ctl_d.hysteresis_select = wr_word.hysteresis_select;
            end
            ctl_d.sensor_shutdown = wr_word.sensor_shutdown & shutdown_may_set;
            ctl_d.critical_limit_lock = crit_lock_next;
            ctl_d.window_limit_lock = wr_word.window_limit_lock;
            ctl_d.critical_only_event = wr_word.critical_only_event;
            ctl_d.event_status = 1'b0;
            ctl_d.event_output_enable = wr_word.event_output_enable;
            ctl_d.event_freeze = wr_word.event_freeze;
            ctl_d.event_polarity = wr_word.event_polarity;
            ctl_d.event_mode = wr_word.event_mode;
        end
    end

    assign ctl_o = ctl_q;
    assign event_clear_o = event_clear_q;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctl_q <= tsr_pkg::tsr_control_t'(tsr_pkg::CTL_RESET);
            event_clear_q <= 1'b0;
        end else if (ce_i) begin
            ctl_q <= ctl_d;
            event_clear_q <= event_clear_d;
        end
    end

endmodule

`default_nettype wire

// file: sim/tsr_regbank_monitor.sv
// Concurrent checks on the ports of the sensor register bank.
`timescale 1ns/1ps
`default_nettype none
module tsr_regbank_monitor (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [15:0] rd_data_o,
    input wire logic rd_hit_o,
    input wire logic [7:0] ptr_o,
    input wire tsr_pkg::tsr_control_t ctl_o,
    input wire logic [5:0] hyst_margin_o,
    input wire logic sensor_enable_o,
    input wire logic event_allowed_o,
    input wire logic event_clear_o,
    input wire logic crit_limit_locked_o
);
    logic rd_go;
    logic wr_ctl;
    assign rd_go = ce_i && rd_en_i;
    assign wr_ctl = ce_i && wr_en_i && ptr_o == 8'h01;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////
    AST_FEAT_READ: assert property (
        rd_go && ptr_o == 8'h00 |=> rd_data_o == 16'h0037 && rd_hit_o)
        else $error("feature word wrong");
    AST_MISS_READ: assert property (
        rd_go && ptr_o > 8'h01 |=> rd_data_o == 16'h0000 && !rd_hit_o)
        else $error("unmapped read not zero");
    AST_RSV_ZERO: assert property (
        ctl_o.reserved_bits == 5'h00 && rd_data_o[15:11] == 5'h00)
        else $error("reserved bits not zero");
    AST_HYST_MARGIN: assert property (
        hyst_margin_o == (ctl_o.hysteresis_select == 2'h0 ? 6'h00
            : 6'h06 << ctl_o.hysteresis_select))
        else $error("margin does not match select");
    AST_SHUT: assert property (
        $past(resetn_i) |-> sensor_enable_o == !ctl_o.sensor_shutdown)
        else $error("sensor enable wrong");
    AST_EVENT_GATE: assert property (
        event_allowed_o |-> sensor_enable_o && ctl_o.event_output_enable)
        else $error("event allowed in shutdown");
    AST_CRIT_STICKY: assert property (crit_limit_locked_o |=> crit_limit_locked_o)
        else $error("critical lock dropped");
    AST_CRIT_SET: assert property (
        wr_ctl && wr_data_i[7] ##1 ce_i |=> crit_limit_locked_o)
        else $error("critical lock not set");
    AST_CTL_WRITE: assert property (
        wr_ctl ##1 ce_i |=> (ctl_o & 16'h006F) == ($past(wr_data_i, 2) & 16'h006F))
        else $error("control bits not written");
    AST_EVENT_CLEAR: assert property (
        wr_ctl && wr_data_i[4] ##1 ce_i |=> event_clear_o)
        else $error("no event clear pulse");
    cover property (rd_go && ptr_o == 8'h00);
    cover property (wr_ctl && wr_data_i[7]);
    cover property (event_clear_o);
    cover property (!ce_i && wr_en_i);
endmodule
bind tsr_regbank tsr_regbank_monitor tsr_regbank_monitor_inst (.clk_sys_i, .resetn_i, .ce_i,
    .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o, .rd_hit_o, .ptr_o, .ctl_o, .hyst_margin_o,
    .sensor_enable_o, .event_allowed_o, .event_clear_o, .crit_limit_locked_o);
`default_nettype wire

// file: sim/tsr_host_model.sv
// Host model issuing pointer, write and read requests to the bank.
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
    input wire logic clk_sys_i,
    output logic ptr_load_o,
    output logic [7:0] ptr_o,
    output logic wr_en_o,
    output logic [15:0] wr_data_o,
    output logic rd_en_o,
    input wire logic [15:0] rd_data_i,
    input wire logic rd_hit_i
);
    initial begin
        ptr_load_o = 1'b0;
        ptr_o = 8'h00;
        wr_en_o = 1'b0;
        wr_data_o = 16'h0000;
        rd_en_o = 1'b0;
    end
    ////////////////////////////////////////
    // Idle buses show inverted data so a stale value can never pass as valid.
    task automatic xfer(input logic wr, input logic [7:0] p, input logic [15:0] d,
                        output logic [15:0] q, output logic hit);
        @(posedge clk_sys_i);
        #1;
        ptr_load_o = 1'b1;
        ptr_o = p;
        @(posedge clk_sys_i);
        #1;
        ptr_load_o = 1'b0;
        ptr_o = ~p;
        wr_en_o = wr;
        rd_en_o = !wr;
        wr_data_o = {5'h00, d[10:0]};
        @(posedge clk_sys_i);
        #1;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        wr_data_o = ~wr_data_o;
        q = rd_data_i;
        hit = rd_hit_i;
    endtask
endmodule
`default_nettype wire

// file: sim/tsr_regbank_test.sv
// Self-checking bench for the sensor register bank.
`timescale 1ns/1ps
`default_nettype none
module tsr_regbank_test;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic event_active_i = 1'b0;
    logic ce = 1'b1;
    logic ptr_load, wr_en, rd_en, rd_hit, hit, sens_en, crit_lk, ev_ok, win_lk;
    logic [7:0] ptr, ptr_now;
    logic [15:0] wr_data, rd_data, q, d, ref_ctl;
    logic [5:0] hyst;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 29;
    always #10 clk_sys_i = ~clk_sys_i;
    tsr_host_model tsr_host_model_inst (.clk_sys_i(clk_sys_i), .ptr_load_o(ptr_load),
        .ptr_o(ptr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en),
        .rd_data_i(rd_data), .rd_hit_i(rd_hit));
    tsr_regbank tsr_regbank_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce),
        .ptr_load_i(ptr_load), .ptr_i(ptr), .wr_en_i(wr_en), .wr_data_i(wr_data),
        .rd_en_i(rd_en), .event_active_i(event_active_i), .rd_data_o(rd_data),
        .rd_hit_o(rd_hit), .ptr_o(ptr_now), .ctl_o(), .hyst_margin_o(hyst),
        .sensor_enable_o(sens_en), .event_allowed_o(ev_ok), .event_clear_o(),
        .crit_limit_locked_o(crit_lk), .win_limits_locked_o(win_lk));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Locks freeze hysteresis and block setting shutdown; the status bit never stores.
    function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] v);
        logic lk;
        lk = c[7] | c[6];
        return {5'h00, lk ? c[10:9] : v[10:9], lk ? c[8] & v[8] : v[8], c[7] | v[7],
                v[6:5], 1'b0, v[3:0]};
    endfunction
    task automatic wr(input logic [15:0] v);
        tsr_host_model_inst.xfer(1'b1, 8'h01, v, q, hit);
        ref_ctl = nxt(ref_ctl, v);
    endtask
    task automatic probe();
        tsr_host_model_inst.xfer(1'b0, 8'h01, 16'h0000, q, hit);
        chk(q, {ref_ctl[15:5], event_active_i & ~ref_ctl[8], ref_ctl[3:0]});
        chk({7'h00, ptr_now, hit}, {7'h00, 8'h01, 1'b1});
        chk({10'h000, hyst}, ref_ctl[10:9] == 2'h0 ? 16'h0 : 16'h6 << ref_ctl[10:9]);
        chk({14'h0000, sens_en, crit_lk}, {14'h0000, ~ref_ctl[8], ref_ctl[7]});
        chk({14'h0, ev_ok, win_lk}, {14'h0, ref_ctl[3] & ~ref_ctl[8], ref_ctl[6]});
    endtask
    task automatic wrap_up();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        ref_ctl = 16'h0000;
        repeat (20) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        probe();
        tsr_host_model_inst.xfer(1'b1, 8'h00, 16'($random(seed)), q, hit);
        tsr_host_model_inst.xfer(1'b0, 8'h00, 16'h0000, q, hit);
        chk(q, 16'h0037);
        chk({15'h0000, hit}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            d[10:9] = i[1:0];
            d[7:6] = 2'h0;
            event_active_i = 1'($random(seed));
            wr(d);
            probe();
        end
        wr(16'h0240);
        wr(16'h0728);
        probe();
        wr(16'h0000);
        probe();
        // With the clock enable low the write below must leave no trace.
        ce = 1'b0;
        tsr_host_model_inst.xfer(1'b1, 8'h01, 16'h0219, q, hit);
        ce = 1'b1;
        probe();
        wr(16'h0219);
        probe();
        wr(16'h0340);
        wr(16'h0000);
        probe();
        tsr_host_model_inst.xfer(1'b0, 8'h02 + 8'($random(seed) & 8'h7F), 16'h0000, q, hit);
        chk(q, 16'h0000);
        chk({15'h0000, hit}, 16'h0000);
        wr(16'h0080);
        wr(16'h0000);
        probe();
        resetn_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        ref_ctl = 16'h0000;
        probe();
        wrap_up();
    end
endmodule
`default_nettype wire
